// file: src/pct_cycle_timing.sv
module pct_cycle_timing
    import pct_pkg::*;
#(
    parameter int DIV = PCLK_DIV
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // AXI4-Lite write channels.
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read channels.
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Card socket.
    output logic [25:0] cardAddressBus,
    output logic [15:0] cardDataOut,
    input wire logic [15:0] cardDataIn,
    output logic cardDataOeN,
    output logic cardCeN,
    output logic cardRegN,
    output logic cardOeN,
    output logic cardWeN,
    output logic cardIordN,
    output logic cardIowrN,
    input wire logic cardWaitN,
    input wire logic cardBvd2,
    input wire logic cardIreqN,
    input wire logic cardStschgN,
    // Host side outputs.
    output logic speakerOutput,
    output logic [15:3] hostInterruptLines,
    output logic irq
);

    generate
        if (DIV < 2) begin : g_bad_div
            $error("DIV must be at least 2");
        end
    endgenerate

    // Setup and hold base counts depend on cycle type and the upper wait bit.
    function automatic logic [4:0] setupBase(input logic io, input logic ws1);
        setupBase = io ? SETUP_IO : (ws1 ? SETUP_MEM_HI : SETUP_MEM_LO);
    endfunction

    function automatic logic [4:0] holdBase(input logic io, input logic ws1);
        holdBase = io ? HOLD_IO : (ws1 ? HOLD_MEM_HI : HOLD_MEM_LO);
    endfunction

    // Strobe count; 16-bit I/O ignores zero-wait since that option does not exist there.
    function automatic logic [4:0] activeBase(input logic io, input logic w16, input logic [1:0] ws,
                                              input logic zero_wait_flag);
        logic [4:0] v;
        v = ACT_MEM8_WSN;
        if (io && w16) begin
            v = ws[0] ? ACT_IO16_WAIT : ACT_IO16_NOWAIT;
        end else if (io) begin
            v = ws[0] ? ACT_IO8_WAIT : (zero_wait_flag ? ACT_IO8_ZWS : ACT_IO8_NOWAIT);
        end else if (w16) begin
            case (ws)
                2'h0: v = zero_wait_flag ? ACT_MEM16_ZWS : ACT_MEM16_WS0;
                2'h1: v = ACT_MEM16_WS1;
                2'h2: v = ACT_MEM16_WS2;
                default: v = ACT_MEM16_WS3;
            endcase
        end else begin
            v = (ws != 2'h0) ? ACT_MEM8_WSN : (zero_wait_flag ? ACT_MEM8_ZWS : ACT_MEM8_WS0);
        end
        activeBase = v;
        return v;
    endfunction

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a[1:0] == 2'h0) && (a <= REG_INT_MASK);
    endfunction

    function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return v;
    endfunction

    // Card pin synchronisers; active-low pins are inverted first so that the cleared chain reads as idle after reset.
    logic [19:0] pinSync;
    pct_sync #(.WIDTH(20)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pinIn({cardDataIn, ~cardStschgN, ~cardIreqN, cardBvd2, ~cardWaitN}),
        .syncOut(pinSync)
    );
    logic waitSync;
    logic ireqSync;
    logic stschgSync;
    logic [15:0] dataSync;
    assign waitSync = pinSync[0];
    assign speakerOutput = pinSync[1];
    assign ireqSync = pinSync[2];
    assign stschgSync = pinSync[3];
    assign dataSync = pinSync[19:4];

    // Bus and register state.
    logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
    logic [7:0] awAddr_r, awAddr_nxt;
    logic [31:0] wData_r, wData_nxt;
    logic [3:0] wStrb_r, wStrb_nxt;
    logic bvalid_nxt, rvalid_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [15:0] wrData_r, wrData_nxt;
    logic [INT_W-1:0] intStat_r, intStat_nxt, intMask_r, intMask_nxt, events;
    logic [15:3] irqLines_nxt;
    logic startReq;
    logic [25:0] startAddr;

    // Card cycle state.
    pct_state_t state_r, state_nxt;
    logic startPend_r, startPend_nxt;
    logic [4:0] phase_r, phase_nxt;
    logic [4:0] setupLen_r, setupLen_nxt, activeLen_r, activeLen_nxt, holdLen_r, holdLen_nxt;
    logic cyIo_r, cyIo_nxt, cyWr_r, cyWr_nxt, cyAttr_r, cyAttr_nxt;
    logic [25:0] addr_nxt;
    logic [15:0] dOut_nxt, rdData_r, rdData_nxt;
    logic [$clog2(DIV)-1:0] div_r, div_nxt;
    logic tick, busy, waitHold;
    logic oeN_nxt, weN_nxt, iordN_nxt, iowrN_nxt, ceN_nxt, regN_nxt, dOeN_nxt;

    assign awready = ~awHeld_r;
    assign wready = ~wHeld_r;
    assign arready = ~rvalid;
    assign busy = startPend_r | (state_r != PCT_IDLE);
    assign irq = |(intStat_r & intMask_r);

    // Bus slave: address and data are held separately and the write lands once both are in.
    always_comb begin
        awHeld_nxt = awHeld_r;
        wHeld_nxt = wHeld_r;
        awAddr_nxt = awAddr_r;
        wData_nxt = wData_r;
        wStrb_nxt = wStrb_r;
        bvalid_nxt = bvalid;
        bresp_nxt = bresp;
        rvalid_nxt = rvalid;
        rresp_nxt = rresp;
        rdata_nxt = rdata;
        ctrl_nxt = ctrl_r;
        wrData_nxt = wrData_r;
        intMask_nxt = intMask_r;
        startReq = 1'b0;
        startAddr = wData_r[25:0];
        intStat_nxt = intStat_r;
        if (awvalid && awready) begin
            awHeld_nxt = 1'b1;
            awAddr_nxt = awaddr;
        end
        if (wvalid && wready) begin
            wHeld_nxt = 1'b1;
            wData_nxt = wdata;
            wStrb_nxt = wstrb;
        end
        if (bvalid && bready) begin
            bvalid_nxt = 1'b0;
        end
        if (awHeld_r && wHeld_r && !bvalid) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
            case (awAddr_r)
                REG_CTRL: ctrl_nxt = applyStrb(ctrl_r, wData_r, wStrb_r) & CTRL_WMASK;
                REG_CMD: startReq = 1'b1;
                REG_DATA: wrData_nxt = 16'(applyStrb({16'h0000, wrData_r}, wData_r, wStrb_r));
                REG_INT_MASK: intMask_nxt = wData_r[INT_W-1:0];
                default: ;
            endcase
        end
        if (rvalid && rready) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                REG_CTRL: rdata_nxt = ctrl_r;
                REG_CMD: rdata_nxt = {6'h00, cardAddressBus};
                REG_DATA: rdata_nxt = {16'h0000, rdData_r};
                REG_STATUS: rdata_nxt = {27'h0, speakerOutput, waitSync, state_r, busy};
                REG_INT_STAT: rdata_nxt = {{(32-INT_W){1'b0}}, intStat_r};
                REG_INT_MASK: rdata_nxt = {{(32-INT_W){1'b0}}, intMask_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
            if (araddr == REG_INT_STAT) begin
                intStat_nxt = '0;
            end
        end
        // A fresh event wins over the read that clears the bit.
        intStat_nxt = intStat_nxt | events;
        for (int i = 3; i <= 15; i++) begin
            irqLines_nxt[i] = (ctrl_r[CTRL_IRQSEL_LSB +: 4] == 4'(i)) && (ireqSync || stschgSync);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
            ctrl_r <= CTRL_RESET;
            wrData_r <= 16'h0000;
            intStat_r <= '0;
            intMask_r <= INT_MASK_RESET;
            hostInterruptLines <= '0;
        end else begin
            awHeld_r <= awHeld_nxt;
            wHeld_r <= wHeld_nxt;
            awAddr_r <= awAddr_nxt;
            wData_r <= wData_nxt;
            wStrb_r <= wStrb_nxt;
            bvalid <= bvalid_nxt;
            bresp <= bresp_nxt;
            rvalid <= rvalid_nxt;
            rresp <= rresp_nxt;
            rdata <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            wrData_r <= wrData_nxt;
            intStat_r <= intStat_nxt;
            intMask_r <= intMask_nxt;
            hostInterruptLines <= irqLines_nxt;
        end
    end

    // Card cycle sequencer; every phase is a whole number of host clock periods.
    assign tick = (div_r == ($clog2(DIV))'(DIV - 1));
    assign waitHold = waitSync && (!cyIo_r || !cyWr_r);
    always_comb begin
        state_nxt = state_r;
        startPend_nxt = startPend_r;
        phase_nxt = phase_r;
        setupLen_nxt = setupLen_r;
        activeLen_nxt = activeLen_r;
        holdLen_nxt = holdLen_r;
        cyIo_nxt = cyIo_r;
        cyWr_nxt = cyWr_r;
        cyAttr_nxt = cyAttr_r;
        addr_nxt = cardAddressBus;
        dOut_nxt = cardDataOut;
        rdData_nxt = rdData_r;
        events = '0;
        div_nxt = tick ? '0 : div_r + 1'b1;
        if (startReq && busy) begin
            events[INT_REFUSED] = 1'b1;
        end else if (startReq) begin
            startPend_nxt = 1'b1;
            addr_nxt = startAddr;
            dOut_nxt = wrData_r;
            cyIo_nxt = ctrl_r[CTRL_IO_BIT];
            cyWr_nxt = ctrl_r[CTRL_WR_BIT];
            cyAttr_nxt = ctrl_r[CTRL_ATTR_BIT];
            setupLen_nxt = setupBase(ctrl_r[CTRL_IO_BIT], ctrl_r[CTRL_WS_LSB+1]) + SETUP_EXTRA;
            holdLen_nxt = holdBase(ctrl_r[CTRL_IO_BIT], ctrl_r[CTRL_WS_LSB+1]) + HOLD_EXTRA;
            activeLen_nxt = activeBase(ctrl_r[CTRL_IO_BIT], ctrl_r[CTRL_W16_BIT],
                                       ctrl_r[CTRL_WS_LSB +: 2], ctrl_r[CTRL_ZWS_BIT]);
            events[INT_ZWS_NA] = ctrl_r[CTRL_IO_BIT] & ctrl_r[CTRL_W16_BIT] & ctrl_r[CTRL_ZWS_BIT];
        end
        if (tick) begin
            case (state_r)
                PCT_IDLE: begin
                    if (startPend_r) begin
                        state_nxt = PCT_SETUP;
                        startPend_nxt = 1'b0;
                        phase_nxt = 5'h0;
                    end
                end
                PCT_SETUP: begin
                    phase_nxt = phase_r + 5'h1;
                    if (phase_r == setupLen_r - 5'h1) begin
                        state_nxt = PCT_ACTIVE;
                        phase_nxt = 5'h0;
                    end
                end
                PCT_ACTIVE: begin
                    if (phase_r < activeLen_r - 5'h1) begin
                        phase_nxt = phase_r + 5'h1;
                    end else if (!waitHold) begin
                        state_nxt = PCT_HOLD;
                        phase_nxt = 5'h0;
                        rdData_nxt = cyWr_r ? rdData_r : dataSync;
                    end
                end
                PCT_HOLD: begin
                    phase_nxt = phase_r + 5'h1;
                    if (phase_r == holdLen_r - 5'h1) begin
                        state_nxt = PCT_IDLE;
                        phase_nxt = 5'h0;
                        events[INT_DONE] = 1'b1;
                    end
                end
                default: state_nxt = PCT_IDLE;
            endcase
        end
        // Strobes and selects follow the next phase so they line up with the registered phase.
        ceN_nxt = (state_nxt == PCT_IDLE);
        regN_nxt = ~(cyAttr_nxt && state_nxt != PCT_IDLE);
        dOeN_nxt = ~(cyWr_nxt && state_nxt != PCT_IDLE);
        oeN_nxt = ~(state_nxt == PCT_ACTIVE && !cyIo_nxt && !cyWr_nxt);
        weN_nxt = ~(state_nxt == PCT_ACTIVE && !cyIo_nxt && cyWr_nxt);
        iordN_nxt = ~(state_nxt == PCT_ACTIVE && cyIo_nxt && !cyWr_nxt);
        iowrN_nxt = ~(state_nxt == PCT_ACTIVE && cyIo_nxt && cyWr_nxt);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= PCT_IDLE;
            startPend_r <= 1'b0;
            phase_r <= 5'h0;
            setupLen_r <= SETUP_MEM_LO;
            activeLen_r <= ACT_MEM16_WS0;
            holdLen_r <= HOLD_MEM_LO;
            cyIo_r <= 1'b0;
            cyWr_r <= 1'b0;
            cyAttr_r <= 1'b0;
            cardAddressBus <= 26'h000_0000;
            cardDataOut <= 16'h0000;
            rdData_r <= 16'h0000;
            div_r <= '0;
            cardCeN <= 1'b1;
            cardRegN <= 1'b1;
            cardDataOeN <= 1'b1;
            cardOeN <= 1'b1;
            cardWeN <= 1'b1;
            cardIordN <= 1'b1;
            cardIowrN <= 1'b1;
        end else begin
            state_r <= state_nxt;
            startPend_r <= startPend_nxt;
            phase_r <= phase_nxt;
            setupLen_r <= setupLen_nxt;
            activeLen_r <= activeLen_nxt;
            holdLen_r <= holdLen_nxt;
            cyIo_r <= cyIo_nxt;
            cyWr_r <= cyWr_nxt;
            cyAttr_r <= cyAttr_nxt;
            cardAddressBus <= addr_nxt;
            cardDataOut <= dOut_nxt;
            rdData_r <= rdData_nxt;
            div_r <= div_nxt;
            cardCeN <= ceN_nxt;
            cardRegN <= regN_nxt;
            cardDataOeN <= dOeN_nxt;
            cardOeN <= oeN_nxt;
            cardWeN <= weN_nxt;
            cardIordN <= iordN_nxt;
            cardIowrN <= iowrN_nxt;
        end
    end

    // Helper clock count per phase, read only by the checks below.
    logic [15:0] stateClk_r;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stateClk_r <= 16'h0000;
        end else if (state_nxt != state_r) begin
            stateClk_r <= 16'h0000;
        end else if (stateClk_r != 16'hFFFF) begin
            stateClk_r <= stateClk_r + 16'h0001;
        end
    end
    logic strobeLow;
    assign strobeLow = ~(cardOeN & cardWeN & cardIordN & cardIowrN);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence seqBvdSteady;
        $stable(cardBvd2) [*5];
    endsequence
    sequence seqLeaveSetup;
        state_r == PCT_SETUP && state_nxt == PCT_ACTIVE;
    endsequence
    sequence seqLeaveActive;
        state_r == PCT_ACTIVE && state_nxt == PCT_HOLD;
    endsequence
    sequence seqLeaveHold;
        state_r == PCT_HOLD && state_nxt == PCT_IDLE;
    endsequence

    AST_SETUP_TIME: assert property (seqLeaveSetup |-> 32'(stateClk_r) + 1 == 32'(setupLen_r) * DIV)
        else $error("setup phase length wrong");
    AST_ACTIVE_MIN: assert property (seqLeaveActive |-> 32'(stateClk_r) + 1 >= 32'(activeLen_r) * DIV)
        else $error("strobe released early");
    AST_ACTIVE_EXACT: assert property ((state_r == PCT_ACTIVE && !waitHold
        && 32'(stateClk_r) + 1 == 32'(activeLen_r) * DIV) |=> state_r == PCT_HOLD && !strobeLow)
        else $error("strobe not released on count");
    AST_HOLD_TIME: assert property (seqLeaveHold |-> 32'(stateClk_r) + 1 == 32'(holdLen_r) * DIV)
        else $error("hold phase length wrong");
    AST_WAIT_STRETCH: assert property ((state_r == PCT_ACTIVE && waitHold) |=> strobeLow)
        else $error("strobe released during wait");
    AST_STROBE_PHASE: assert property (strobeLow == (state_r == PCT_ACTIVE))
        else $error("strobe outside active phase");
    AST_ADDR_STABLE: assert property ((state_r != PCT_IDLE && $past(state_r) != PCT_IDLE)
        |-> $stable(cardAddressBus) && $stable(cardRegN))
        else $error("address moved during cycle");
    AST_SPEAKER: assert property (seqBvdSteady |-> speakerOutput == cardBvd2)
        else $error("speaker does not follow card level");
    AST_IRQ_ONEHOT: assert property ($onehot0(hostInterruptLines))
        else $error("more than one host line driven");

endmodule

// file: src/pct_pkg.sv
package pct_pkg;

    // Clock rates; the card timing base is one host bus clock period.
    localparam int CLK_PERIOD_NS = 5;
    localparam int PCLK_PERIOD_NS = 30;
    localparam int PCLK_DIV = (PCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Interval counts in host bus clock periods.
    localparam logic [4:0] SETUP_IO = 5'h3;
    localparam logic [4:0] SETUP_MEM_LO = 5'h2;
    localparam logic [4:0] SETUP_MEM_HI = 5'h4;
    localparam logic [4:0] SETUP_EXTRA = 5'h2;
    localparam logic [4:0] HOLD_IO = 5'h2;
    localparam logic [4:0] HOLD_MEM_LO = 5'h2;
    localparam logic [4:0] HOLD_MEM_HI = 5'h3;
    localparam logic [4:0] HOLD_EXTRA = 5'h1;
    localparam logic [4:0] ACT_IO16_NOWAIT = 5'h7;
    localparam logic [4:0] ACT_IO16_WAIT = 5'hB;
    localparam logic [4:0] ACT_MEM16_WS0 = 5'h9;
    localparam logic [4:0] ACT_MEM16_WS1 = 5'hD;
    localparam logic [4:0] ACT_MEM16_WS2 = 5'h11;
    localparam logic [4:0] ACT_MEM16_WS3 = 5'h17;
    localparam logic [4:0] ACT_MEM16_ZWS = 5'h5;
    localparam logic [4:0] ACT_IO8_NOWAIT = 5'h13;
    localparam logic [4:0] ACT_IO8_WAIT = 5'h17;
    localparam logic [4:0] ACT_IO8_ZWS = 5'h7;
    localparam logic [4:0] ACT_MEM8_WS0 = 5'h13;
    localparam logic [4:0] ACT_MEM8_WSN = 5'h17;
    localparam logic [4:0] ACT_MEM8_ZWS = 5'h7;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;

    // Control field positions, writable bits and reset value.
    localparam int CTRL_WS_LSB = 0;
    localparam int CTRL_ZWS_BIT = 2;
    localparam int CTRL_W16_BIT = 3;
    localparam int CTRL_IO_BIT = 4;
    localparam int CTRL_WR_BIT = 5;
    localparam int CTRL_ATTR_BIT = 6;
    localparam int CTRL_IRQSEL_LSB = 8;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_0F7F;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Interrupt status bits and mask reset value.
    localparam int INT_W = 3;
    localparam int INT_DONE = 0;
    localparam int INT_REFUSED = 1;
    localparam int INT_ZWS_NA = 2;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Card cycle phases.
    typedef enum logic [1:0] {
        PCT_IDLE = 2'b00,
        PCT_SETUP = 2'b01,
        PCT_ACTIVE = 2'b10,
        PCT_HOLD = 2'b11
    } pct_state_t;

endpackage

// file: src/pct_sync.sv
module pct_sync
    import pct_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Pins and their settled levels.
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] out_nxt;

    // A level is taken only once the second and third stages agree, which filters a late-settling edge.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_comb begin
                out_nxt[gi] = (stage2_r[gi] == stage3_r[gi]) ? stage3_r[gi] : syncOut[gi];
            end
        end
    endgenerate

    // Three-stage chain; only the second stage reads the first.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
            syncOut <= '0;
        end else begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            syncOut <= out_nxt;
        end
    end

endmodule

// file: testbench/pct_card_model.sv
module pct_card_model (
    // Clock, reset and socket strobes.
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cardCeN,
    input wire logic strobeN,
    input wire logic [7:0] waitLen,
    // Card answers.
    output logic cardWaitN,
    output logic [15:0] cardDataIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_r;
    logic strobe_r;
    // Wait starts only after the strobe has fallen, as a slow card does.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
            strobe_r <= 1'b1;
        end else begin
            strobe_r <= strobeN;
            if (strobe_r && !strobeN)
                cnt_r <= waitLen;
            else if (cnt_r != 8'h00)
                cnt_r <= cnt_r - 8'h01;
        end
    end
    assign cardWaitN = (cnt_r == 8'h00);
    // An unselected card floats its data, shown as the inverse pattern.
    assign cardDataIn = cardCeN ? 16'h5A3C : 16'hA5C3;
endmodule

// file: testbench/pct_cycle_timing_bench.sv
module pct_cycle_timing_bench import pct_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int D = 2;
    logic clk_sys, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, waitLen;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [25:0] cardAddressBus;
    logic [15:0] cardDataOut, cardDataIn;
    logic cardDataOeN, cardCeN, cardRegN, cardOeN, cardWeN, cardIordN, cardIowrN, cardWaitN;
    logic cardBvd2, cardIreqN, cardStschgN, speakerOutput, irq, strb;
    logic [15:3] hostInterruptLines;
    int n_mismatch = 0;
    int comparisons = 0;
    int s, a, h;
    // Entry: control byte, strobe, setup and hold in host periods.
    logic [31:0] t [17] = '{32'h0809_0403, 32'h090D_0403, 32'h2A11_0604, 32'h0B17_0604,
        32'h0C05_0403, 32'h1807_0503, 32'h390B_0503, 32'h1013_0503, 32'h3117_0503, 32'h1407_0503,
        32'h0013_0403, 32'h6117_0403, 32'h0617_0604, 32'h0407_0403, 32'h1C07_0503, 32'h0809_0403,
        32'h1807_0503};
    assign strb = cardOeN & cardWeN & cardIordN & cardIowrN;
    pct_cycle_timing #(.DIV(D)) u_pct_cycle_timing (.*);
    pct_card_model u_pct_card_model (.clk_sys, .nrst, .cardCeN, .strobeN(strb), .waitLen, .cardWaitN,
        .cardDataIn);
    // Clock of 5 ns.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // A hang is cut after far more clocks than the tests need.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One register access; handshakes are sampled mid-cycle so the edge itself never races.
    task automatic bus(input bit w, input logic [7:0] ad, input logic [31:0] d);
        logic ta, tw, tb;
        {awaddr, araddr, wdata, wstrb} <= {ad, ad, d, 4'hF};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk_sys);
            {ta, tw, tb} = {w ? awready : arready, wready, w ? bvalid : rvalid};
            {v, r} = {rdata, w ? bresp : rresp};
            @(posedge clk_sys);
            {awvalid, wvalid, arvalid} <= {awvalid && !ta, wvalid && !tw, arvalid && !ta};
        end
        {bready, rready} <= 2'b00;
        @(posedge clk_sys);
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, nrst} = '0;
        {awaddr, araddr, wdata, wstrb, waitLen} = '0;
        {cardBvd2, cardIreqN, cardStschgN} = 3'b011;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        bus(1, REG_DATA, 32'h0000_C0DE);
        chk(r, RESP_OKAY);
        // Each card cycle gets a second start while busy; the last two meet card wait.
        foreach (t[i]) begin
            bus(1, REG_CTRL, {24'h0, t[i][31:24]});
            waitLen <= (i > 14) ? 8'h28 : 8'h00;
            fork
                begin
                    @(negedge clk_sys);
                    while (cardCeN) @(negedge clk_sys);
                    for (s = 0; strb; s++) @(negedge clk_sys);
                    chk({6'h0, cardAddressBus}, 32'h0000_0123);
                    chk({cardDataOut, cardOeN, cardWeN, cardIordN, cardIowrN, cardRegN, cardDataOeN},
                        {16'hC0DE, ~(~t[i][28] & ~t[i][29]), ~(~t[i][28] & t[i][29]), ~(t[i][28] & ~t[i][29]),
                        ~(t[i][28] & t[i][29]), ~t[i][30], ~t[i][29]});
                    for (a = 0; !strb; a++) @(negedge clk_sys);
                    for (h = 0; !cardCeN; h++) @(negedge clk_sys);
                end
                begin
                    bus(1, REG_CMD, 32'h0000_0123);
                    bus(1, REG_CMD, 32'h0000_0456);
                end
            join
            chk(s, t[i][15:8] * D);
            chk(i > 14 ? a > t[i][23:16] * D : a == t[i][23:16] * D, 1);
            chk(h, t[i][7:0] * D);
            repeat (4 * D) @(negedge clk_sys);
            chk(cardCeN, 1);
            $display("card cycle test %0d ended", i);
            @(posedge clk_sys);
        end
        bus(1, REG_INT_MASK, 32'h0000_0002);
        chk(irq, 1);
        bus(0, REG_INT_STAT, 0);
        chk(v, 32'h0000_0007);
        chk(irq, 0);
        bus(0, 8'h40, 0);
        chk(r, RESP_SLVERR);
        bus(1, 8'h42, 0);
        chk(r, RESP_SLVERR);
        bus(0, REG_DATA, 0);
        chk(v, 32'h0000_A5C3);
        $display("register test ended");
        bus(1, REG_CTRL, 32'h0000_0500);
        for (int k = 0; k < 3; k++) begin
            {cardBvd2, cardIreqN, cardStschgN} <= {k[0], k[0], !k[0]};
            repeat (8) @(negedge clk_sys);
            chk(speakerOutput, k[0]);
            chk(hostInterruptLines, 13'h0004);
            @(posedge clk_sys);
        end
        $display("pin routing test ended");
        complete_run();
    end
endmodule
